// File: rtl/tsxtw_core.sv
// decode and execute of file-test-skip, literal xor and table write
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "tsxtw_consts.svh"
module tsxtw_core (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // data memory access for the tested file register, and the busy flag
    output logic [11:0]      file_addr,
    output logic             file_indexed,
    output logic             busy
);
    import tsxtw_pkg::*;

    // software-visible state
    logic [15:0]       instr_word;
    logic [15:0]       next_word;
    tsxtw_byte_t       file_value;
    tsxtw_byte_t       accum;
    logic [3:0]        bank_select_reg;
    tsxtw_byte_t       table_byte_latch;
    logic [20:0]       program_byte_pointer;
    logic [15:0]       hold_word;
    logic              flag_n;
    logic              flag_z;
    logic              skip_seen;
    logic              ext_enable;
    tsxtw_state_e      state;
    logic [1:0]        cycles;
    // next values
    logic [15:0]       next_instr_word;
    logic [15:0]       next_next_word;
    tsxtw_byte_t       next_file_value;
    tsxtw_byte_t       next_accum;
    logic [3:0]        next_bank_select_reg;
    tsxtw_byte_t       next_table_byte_latch;
    logic [20:0]       next_program_byte_pointer;
    logic [15:0]       next_hold_word;
    logic              next_flag_n;
    logic              next_flag_z;
    logic              next_skip_seen;
    logic              next_ext_enable;
    tsxtw_state_e      next_state;
    logic [1:0]        next_cycles;
    logic [11:0]       next_file_addr;
    logic              next_file_indexed;
    // bus slave state
    logic              aw_held;
    logic              w_held;
    logic [7:0]        aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              next_aw_held;
    logic              next_w_held;
    logic [7:0]        next_aw_addr;
    logic [31:0]       next_w_data;
    logic [3:0]        next_w_strb;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_rvalid;
    logic [1:0]        next_rresp;
    logic [31:0]       next_rdata;

    logic              do_write;
    logic              do_read;
    logic              go;

    // merges byte enables over an old word
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // two-word instructions of the core start with 1100 or 1110
    function automatic logic two_word(input logic [15:0] w);
        return (w[15:12] == 4'hC) || (w[15:9] == 7'h76) ||
               (w[15:8] == 8'hEC) || (w[15:8] == 8'hED) ||
               (w[15:8] == 8'hEF) || (w[15:8] == 8'hEE) ||
               (w[15:8] == 8'hEB);
    endfunction

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = (aw_held || s_axi_awvalid) &&
                      (w_held || s_axi_wvalid) && !s_axi_bvalid;
    assign do_read  = s_axi_arvalid && !s_axi_rvalid;

    always_comb begin
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic [7:0]  xr;
        wa = aw_held ? aw_addr : s_axi_awaddr;
        wd = w_held ? w_data : s_axi_wdata;
        ws = w_held ? w_strb : s_axi_wstrb;
        xr = 8'h00;
        go = 1'b0;
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid && !s_axi_bready;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid && !s_axi_rready;
        next_rresp   = s_axi_rresp;
        next_rdata   = s_axi_rdata;
        next_instr_word = instr_word;
        next_next_word  = next_word;
        next_file_value = file_value;
        next_accum      = accum;
        next_bank_select_reg = bank_select_reg;
        next_table_byte_latch = table_byte_latch;
        next_program_byte_pointer = program_byte_pointer;
        next_hold_word  = hold_word;
        next_flag_n     = flag_n;
        next_flag_z     = flag_z;
        next_skip_seen  = skip_seen;
        next_ext_enable = ext_enable;
        next_state      = state;
        next_cycles     = cycles;
        next_file_addr  = file_addr;
        next_file_indexed = file_indexed;

        if (s_axi_awvalid && s_axi_awready && !do_write) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready && !do_write) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end

        // execution sequencer; nop cycles model the discarded fetches
        case (state)
            TSXTW_IDLE: ;
            TSXTW_NOP1: begin
                next_cycles = cycles + 2'h1;
                if (instr_word[15:2] == `TSXTW_OP_TBLWR) begin
                    // second cycle: latch byte into holding word
                    if (program_byte_pointer[0]) begin
                        next_hold_word[15:8] = table_byte_latch;
                    end else begin
                        next_hold_word[7:0] = table_byte_latch;
                    end
                    case (instr_word[1:0])
                        2'h1: next_program_byte_pointer =
                                  program_byte_pointer + 21'h1;
                        2'h2: next_program_byte_pointer =
                                  program_byte_pointer - 21'h1;
                        default: ;
                    endcase
                    next_state = TSXTW_IDLE;
                end else if (two_word(next_word)) begin
                    next_state = TSXTW_NOP2;
                end else begin
                    next_state = TSXTW_IDLE;
                end
            end
            TSXTW_NOP2: begin
                next_cycles = cycles + 2'h1;
                next_state = TSXTW_IDLE;
            end
            default: next_state = TSXTW_IDLE;
        endcase

        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = `TSXTW_RESP_OKAY;
            case ({wa[7:2], 2'b00})
                `TSXTW_REG_INSTR: next_instr_word =
                    16'(merge({16'h0000, instr_word}, wd, ws));
                `TSXTW_REG_NEXTW: next_next_word =
                    16'(merge({16'h0000, next_word}, wd, ws));
                `TSXTW_REG_FILE:  if (ws[0]) next_file_value = wd[7:0];
                `TSXTW_REG_ACCUM: if (ws[0]) next_accum = wd[7:0];
                `TSXTW_REG_BANK:  if (ws[0])
                    next_bank_select_reg = wd[3:0];
                `TSXTW_REG_TBLAT: if (ws[0])
                    next_table_byte_latch = wd[7:0];
                `TSXTW_REG_PTR:   next_program_byte_pointer =
                    21'(merge({11'h000, program_byte_pointer}, wd, ws));
                `TSXTW_REG_HOLD:  next_hold_word =
                    16'(merge({16'h0000, hold_word}, wd, ws));
                `TSXTW_REG_CTRL: begin
                    if (ws[0]) begin
                        next_ext_enable = wd[1];
                        go = wd[0] && (state == TSXTW_IDLE);
                    end
                end
                default: next_bresp = `TSXTW_RESP_SLVERR;
            endcase
        end

        // start of an instruction: decode and first cycle
        if (go) begin
            next_cycles = 2'h1;
            next_skip_seen = 1'b0;
            if (instr_word[15:9] == `TSXTW_OP_TEST_FILE_SKIP_IF_ZERO) begin
                if (!instr_word[8] && ext_enable &&
                    instr_word[7:0] <= `TSXTW_ILO_MAX) begin
                    next_file_indexed = 1'b1;
                    next_file_addr = {4'h0, instr_word[7:0]};
                end else if (!instr_word[8]) begin
                    next_file_indexed = 1'b0;
                    next_file_addr = {{4{instr_word[7]}}, instr_word[7:0]};
                end else begin
                    next_file_indexed = 1'b0;
                    next_file_addr = {bank_select_reg, instr_word[7:0]};
                end
                if (file_value == 8'h00) begin
                    next_skip_seen = 1'b1;
                    next_state = TSXTW_NOP1;
                end
            end else if (instr_word[15:8] == `TSXTW_OP_XORLIT) begin
                xr = accum ^ instr_word[7:0];
                next_accum  = xr;
                next_flag_n = xr[7];
                next_flag_z = (xr == 8'h00);
            end else if (instr_word[15:2] == `TSXTW_OP_TBLWR) begin
                if (instr_word[1:0] == 2'h3) begin
                    next_program_byte_pointer = program_byte_pointer + 21'h1;
                end
                next_state = TSXTW_NOP1;
            end
        end

        if (do_read) begin
            next_rvalid = 1'b1;
            next_rresp  = `TSXTW_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                `TSXTW_REG_INSTR: next_rdata = {16'h0000, instr_word};
                `TSXTW_REG_NEXTW: next_rdata = {16'h0000, next_word};
                `TSXTW_REG_FILE:  next_rdata = {24'h000000, file_value};
                `TSXTW_REG_ACCUM: next_rdata = {24'h000000, accum};
                `TSXTW_REG_BANK:
                    next_rdata = {28'h0000000, bank_select_reg};
                `TSXTW_REG_TBLAT:
                    next_rdata = {24'h000000, table_byte_latch};
                `TSXTW_REG_PTR:
                    next_rdata = {11'h000, program_byte_pointer};
                `TSXTW_REG_HOLD:  next_rdata = {16'h0000, hold_word};
                `TSXTW_REG_STATUS:
                    next_rdata = {20'h00000, file_addr[11:8], cycles,
                                  file_indexed, skip_seen,
                                  state != TSXTW_IDLE, 1'b0, flag_n, flag_z};
                `TSXTW_REG_CTRL:  next_rdata = {30'h0, ext_enable, 1'b0};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = `TSXTW_RESP_SLVERR;
                end
            endcase
        end
    end

    assign busy = (state != TSXTW_IDLE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000;
            instr_word <= 16'h0000;
            next_word <= 16'h0000;
            file_value <= 8'h00;
            accum <= 8'h00;
            bank_select_reg <= 4'h0;
            table_byte_latch <= 8'h00;
            program_byte_pointer <= 21'h000000;
            hold_word <= 16'hFFFF;
            flag_n <= 1'b0;
            flag_z <= 1'b0;
            skip_seen <= 1'b0;
            ext_enable <= 1'b0;
            state <= TSXTW_IDLE;
            cycles <= 2'h0;
            file_addr <= 12'h000;
            file_indexed <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            instr_word <= next_instr_word;
            next_word <= next_next_word;
            file_value <= next_file_value;
            accum <= next_accum;
            bank_select_reg <= next_bank_select_reg;
            table_byte_latch <= next_table_byte_latch;
            program_byte_pointer <= next_program_byte_pointer;
            hold_word <= next_hold_word;
            flag_n <= next_flag_n;
            flag_z <= next_flag_z;
            skip_seen <= next_skip_seen;
            ext_enable <= next_ext_enable;
            state <= next_state;
            cycles <= next_cycles;
            file_addr <= next_file_addr;
            file_indexed <= next_file_indexed;
        end
    end
endmodule
`default_nettype wire

// File: rtl/tsxtw_consts.svh
// timing counts, opcode fields and register offsets for the decoder block
`ifndef TSXTW_CONSTS_SVH
`define TSXTW_CONSTS_SVH
`define TSXTW_OP_TEST_FILE_SKIP_IF_ZERO    7'h33
`define TSXTW_OP_XORLIT    8'h0A
`define TSXTW_OP_TBLWR     14'h0003
`define TSXTW_ILO_MAX      8'h5F
`define TSXTW_CYC_TBLWR    2'h2
`define TSXTW_CYC_SKIP1    2'h2
`define TSXTW_CYC_SKIP2    2'h3
`define TSXTW_REG_INSTR    8'h00
`define TSXTW_REG_NEXTW    8'h04
`define TSXTW_REG_FILE     8'h08
`define TSXTW_REG_ACCUM    8'h0C
`define TSXTW_REG_BANK     8'h10
`define TSXTW_REG_TBLAT    8'h14
`define TSXTW_REG_PTR      8'h18
`define TSXTW_REG_HOLD     8'h1C
`define TSXTW_REG_STATUS   8'h20
`define TSXTW_REG_CTRL     8'h24
`define TSXTW_RESP_OKAY    2'h0
`define TSXTW_RESP_SLVERR  2'h2
`endif

// File: rtl/tsxtw_pkg.sv
// types shared by the decoder block
package tsxtw_pkg;
    typedef enum logic [1:0] {
        TSXTW_IDLE,
        TSXTW_NOP1,
        TSXTW_NOP2
    } tsxtw_state_e;
    typedef logic [7:0] tsxtw_byte_t;
endpackage

// File: dv/tsxtw_core_chk.sv
// checker for the decoder block, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module tsxtw_core_chk (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // axi4-lite write side
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // axi4-lite read side
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // file access and busy flag
    input wire logic [11:0] file_addr,
    input wire logic        file_indexed,
    input wire logic        busy
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("write response dropped early");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken with response pending");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken with data pending");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read data late");
    a_busy_release: assert property ($rose(busy) |-> ##[1:2] !busy)
        else $error("extra cycles run too long");
    a_indexed_range: assert property (file_indexed |->
        file_addr[11:8] == 4'h0 && file_addr[7:0] <= 8'h5F)
        else $error("indexed address out of range");
    c_two_extra: cover property (busy ##1 busy);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    c_indexed: cover property ($rose(file_indexed));
endmodule
bind tsxtw_core tsxtw_core_chk chk_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .file_addr(file_addr),
    .file_indexed(file_indexed), .busy(busy));
`default_nettype wire

// File: dv/tb_test_skip_xor_table_write.sv
// self-checking bench for the decoder block
`timescale 1ns/100ps
`default_nettype none
`include "tsxtw_consts.svh"
module tb_test_skip_xor_table_write;
    typedef struct packed {logic [7:0] w, k, r; logic n, z;} tsxtw_xrow_s;
    logic        aclk, aresetn, ext;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, br;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, file_indexed, busy;
    logic [11:0] file_addr;
    int          n_errors, cmp_count;
    tsxtw_xrow_s xr [3];
    tsxtw_core dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .file_addr(file_addr),
        .file_indexed(file_indexed), .busy(busy));
    always #4 aclk = ~aclk;
    task automatic chk(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // handshakes are judged at the falling edge: inputs only move at rising
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ha, hw, hb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end while (!hb);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic ha, hr;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ha = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'b0;
        end while (!hr);
        s_axi_rready <= 1'b0;
    endtask
    task automatic exe(input logic [15:0] ins, input logic [15:0] nxt);
        int n;
        wr(`TSXTW_REG_INSTR, {16'h0, ins});
        wr(`TSXTW_REG_NEXTW, {16'h0, nxt});
        // decode sees the enable already stored, so set it first
        wr(`TSXTW_REG_CTRL, {30'h0, ext, 1'b0});
        wr(`TSXTW_REG_CTRL, {30'h0, ext, 1'b1});
        n = 0;
        @(negedge aclk);
        while (busy !== 1'b0 && n < 10) begin
            @(negedge aclk);
            n++;
        end
        chk("busy done", {31'h0, busy}, 32'h0);
    endtask
    task automatic tst(input logic [8:0] af, input logic [7:0] fv,
            input logic [15:0] nxt, input logic [1:0] cyc,
            input logic [11:0] fa, input logic idx);
        wr(`TSXTW_REG_FILE, {24'h0, fv});
        exe({7'h33, af}, nxt);
        rd(`TSXTW_REG_STATUS);
        chk("cycles", {30'h0, d[7:6]}, {30'h0, cyc});
        chk("skip", {31'h0, d[4]}, {31'h0, fv == 8'h00});
        chk("file_addr", {20'h0, file_addr}, {20'h0, fa});
        chk("status bank", {28'h0, d[11:8]}, {28'h0, fa[11:8]});
        chk("indexed", {31'h0, file_indexed}, {31'h0, idx});
    endtask
    task automatic tw(input logic [7:0] lat, input logic [1:0] nn,
            input logic [15:0] hold, input logic [20:0] ptr);
        wr(`TSXTW_REG_TBLAT, {24'h0, lat});
        exe({14'h0003, nn}, 16'h0);
        rd(`TSXTW_REG_HOLD);
        chk("hold", d, {16'h0, hold});
        rd(`TSXTW_REG_PTR);
        chk("pointer", d, {11'h0, ptr});
        rd(`TSXTW_REG_STATUS);
        chk("tw cycles", {30'h0, d[7:6]}, {30'h0, `TSXTW_CYC_TBLWR});
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        close_out();
    end
    initial begin
        {aclk, aresetn, ext, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        n_errors = 0;
        cmp_count = 0;
        xr = '{'{8'hB5, 8'hAF, 8'h1A, 1'b0, 1'b0},
               '{8'h80, 8'h00, 8'h80, 1'b1, 1'b0},
               '{8'h5A, 8'h5A, 8'h00, 1'b0, 1'b1}};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`TSXTW_REG_HOLD);
        chk("hold reset", d, 32'h0000FFFF);
        chk("busy reset", {31'h0, busy}, 32'h0);
        $display("test reset done");
        foreach (xr[i]) begin
            wr(`TSXTW_REG_ACCUM, {24'h0, xr[i].w});
            exe({8'h0A, xr[i].k}, 16'h0);
            rd(`TSXTW_REG_ACCUM);
            chk("accum", d, {24'h0, xr[i].r});
            rd(`TSXTW_REG_STATUS);
            chk("flags", {30'h0, d[1:0]}, {30'h0, xr[i].n, xr[i].z});
            chk("xor cycles", {30'h0, d[7:6]}, 32'h1);
        end
        $display("test xor done");
        wr(`TSXTW_REG_BANK, 32'h5);
        tst(9'h090, 8'h05, 16'h0000, 2'h1, 12'hF90, 1'b0);
        tst(9'h010, 8'h00, 16'h0A00, 2'h2, 12'h010, 1'b0);
        tst(9'h123, 8'h00, 16'hC123, 2'h3, 12'h523, 1'b0);
        ext = 1'b1;
        tst(9'h05F, 8'h01, 16'h0000, 2'h1, 12'h05F, 1'b1);
        tst(9'h060, 8'h00, 16'hC000, 2'h3, 12'h060, 1'b0);
        tst(9'h15F, 8'h00, 16'h0000, 2'h2, 12'h55F, 1'b0);
        ext = 1'b0;
        $display("test skip done");
        wr(`TSXTW_REG_PTR, 32'h00A356);
        tw(8'h55, 2'h1, 16'hFF55, 21'h00A357);
        tw(8'h34, 2'h0, 16'h3455, 21'h00A357);
        tw(8'h77, 2'h3, 16'h3477, 21'h00A358);
        tw(8'h11, 2'h2, 16'h3411, 21'h00A357);
        $display("test table write done");
        rd(8'h30);
        chk("unmapped resp", {30'h0, r}, {30'h0, `TSXTW_RESP_SLVERR});
        chk("unmapped data", d, 32'h0);
        wr(8'h30, 32'h1);
        chk("unmapped wresp", {30'h0, br}, {30'h0, `TSXTW_RESP_SLVERR});
        $display("test unmapped done");
        close_out();
    end
endmodule
`default_nettype wire
